// File: verilog/ssf_host.sv
// serial programmer controller that drives the flash command port
// ------------------------------------------------------------
// Operation
// - reset released with clock mode select pin high enters sync mode
// - serial input bits are sampled on transfer clock rising edge
// - every transfer is one byte, least significant bit first
// - never start the next byte before busy is seen low
// - address commands send middle byte second, high byte third
// - opcode 41 plus address takes 256 data bytes from byte four
// - never program a page again before it has been erased; the code refuses only a repeat of the last programmed page
// - block erase is 20, address, then D0 confirm in byte four
// - block erase address is the highest address in the block
// - A7 then D0 erases every unlocked block
// ------------------------------------------------------------
`timescale 1ns/1ps
module ssf_host
  import ssf_pkg::*;
(
  // clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // command request
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [15:0] cmd_addr_in,
  input wire logic [55:0] cmd_id_in,
  output logic cmd_ready_out,
  // page program data
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  output logic wr_ready_out,
  // data returned by the device
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  // command result
  output logic done_out,
  output logic refused_out,
  output logic mode_ready_out,
  // device pins
  output logic dev_reset_n_out,
  output logic transfer_clock_pin_out,
  output logic serial_input_pin_out,
  input wire logic serial_output_pin_in,
  input wire logic busy_output_pin_in
);
  import ssf_pkg::*;

  ssf_state_t state;
  logic [7:0] op;
  logic [15:0] addr;
  logic [55:0] id_code;
  logic [8:0] idx;
  logic [8:0] last;
  logic [7:0] rst_cnt;
  logic [3:0] guard_cnt;
  logic rx_meta;
  logic rx_sync;
  logic busy_meta;
  logic busy_sync;
  logic [15:0] last_page;
  logic last_page_valid;
  logic sh_start;
  logic sh_done;
  logic [7:0] sh_tx;
  logic [7:0] sh_rx;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;
  logic data_slot;
  logic [8:0] cmd_len;

  // ------------------------------------------------------------
  // command framing helpers
  // ------------------------------------------------------------
  function automatic logic [8:0] op_len(input logic [7:0] code);
    case (code)
      OP_PAGE_READ, OP_BOOT_READ, OP_PAGE_PROG: op_len = LEN_PAGE;
      OP_BLOCK_ERASE, OP_LOCK_PROG, OP_LOCK_STATUS: begin
        op_len = LEN_ADDR_CONF;
      end
      OP_ERASE_ALL: op_len = LEN_CONF;
      OP_READ_STATUS, OP_CHECK_DATA: op_len = LEN_STATUS;
      OP_CLEAR_STATUS, OP_LOCK_ENABLE, OP_LOCK_DISABLE: begin
        op_len = LEN_SINGLE;
      end
      OP_VERSION: op_len = LEN_VERSION;
      OP_ID_CHECK: op_len = LEN_ID;
      default: op_len = '0;
    endcase
  endfunction

  function automatic logic [7:0] tx_of(
    input logic [7:0] code,
    input logic [8:0] i,
    input logic [15:0] a,
    input logic [55:0] id
  );
    logic [8:0] k;
    k = i - IDX_ID;
    tx_of = TX_FILL;
    if (i == '0) begin
      tx_of = code;
    end else if (code == OP_ERASE_ALL) begin
      tx_of = CONFIRM;
    end else if (code == OP_ID_CHECK) begin
      case (i)
        9'h001: tx_of = ID_ADDR[7:0];
        9'h002: tx_of = ID_ADDR[15:8];
        9'h003: tx_of = ID_ADDR[23:16];
        9'h004: tx_of = ID_LEN;
        default: tx_of = id[k[2:0]*8 +: 8];
      endcase
    end else if (code == OP_PAGE_READ || code == OP_PAGE_PROG ||
                 code == OP_BLOCK_ERASE || code == OP_LOCK_PROG ||
                 code == OP_LOCK_STATUS || code == OP_BOOT_READ) begin
      if (i == 9'h001) begin
        tx_of = a[7:0];
      end else if (i == 9'h002) begin
        tx_of = a[15:8];
      end else if (code == OP_BLOCK_ERASE || code == OP_LOCK_PROG) begin
        tx_of = CONFIRM;
      end
    end
  endfunction

  function automatic logic is_read(
    input logic [7:0] code,
    input logic [8:0] i
  );
    case (code)
      OP_PAGE_READ: is_read = i >= IDX_DATA;
      OP_BOOT_READ: is_read = i >= IDX_DATA;
      OP_LOCK_STATUS: is_read = i == IDX_DATA;
      OP_READ_STATUS: is_read = i != '0;
      OP_CHECK_DATA: is_read = i != '0;
      OP_VERSION: is_read = i != '0;
      default: is_read = 1'b0;
    endcase
  endfunction

  assign cmd_len = op_len(cmd_opcode_in);
  assign data_slot = op == OP_PAGE_PROG && idx >= IDX_DATA;
  assign sh_start = state == ST_WAIT && !busy_sync && idx != last &&
                    (!data_slot || fifo_valid);
  assign fifo_pop = sh_start && data_slot;
  assign sh_tx = data_slot ? fifo_data : tx_of(op, idx, addr, id_code);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_meta <= 1'b0;
      rx_sync <= 1'b0;
      busy_meta <= 1'b1;
      busy_sync <= 1'b1;
    end else if (ce_in) begin
      rx_meta <= serial_output_pin_in;
      rx_sync <= rx_meta;
      busy_meta <= busy_output_pin_in;
      busy_sync <= busy_meta;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_RESET;
      rst_cnt <= '0;
      guard_cnt <= '0;
      idx <= '0;
      last <= '0;
      op <= '0;
      addr <= '0;
      id_code <= '0;
      dev_reset_n_out <= 1'b0;
      mode_ready_out <= 1'b0;
      cmd_ready_out <= 1'b0;
      done_out <= 1'b0;
      refused_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      refused_out <= 1'b0;
      case (state)
        ST_RESET: begin
          // transfer clock idles high, so it is high at release
          rst_cnt <= rst_cnt + 8'h01;
          if (rst_cnt == RESET_CYC - 8'h01) begin
            dev_reset_n_out <= 1'b1;
            guard_cnt <= '0;
            idx <= '0;
            last <= '0;
            state <= ST_GUARD;
          end
        end
        ST_IDLE: begin
          if (cmd_valid_in) begin
            if (cmd_len == '0 ||
                (cmd_opcode_in == OP_PAGE_PROG && last_page_valid &&
                 last_page == cmd_addr_in)) begin
              refused_out <= 1'b1;
            end else begin
              cmd_ready_out <= 1'b0;
              op <= cmd_opcode_in;
              addr <= cmd_addr_in;
              id_code <= cmd_id_in;
              last <= cmd_len;
              idx <= '0;
              state <= ST_WAIT;
            end
          end
        end
        ST_GUARD: begin
          // busy may lag the last clock edge; give it time to rise
          guard_cnt <= guard_cnt + 4'h1;
          if (guard_cnt == GUARD_CYC - 4'h1) begin
            guard_cnt <= '0;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!busy_sync) begin
            if (idx == last) begin
              // erase and program results are readable from here
              done_out <= mode_ready_out;
              mode_ready_out <= 1'b1;
              cmd_ready_out <= 1'b1;
              state <= ST_IDLE;
            end else if (sh_start) begin
              state <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          if (sh_done) begin
            idx <= idx + 9'h001;
            state <= ST_GUARD;
          end
        end
        default: begin
          state <= ST_RESET;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // returned data
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else if (ce_in) begin
      rd_valid_out <= 1'b0;
      if (state == ST_SHIFT && sh_done && is_read(op, idx)) begin
        rd_valid_out <= 1'b1;
        rd_data_out <= sh_rx;
      end
    end
  end

  // ------------------------------------------------------------
  // programmed page guard, cleared by any erase
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      last_page <= '0;
      last_page_valid <= 1'b0;
    end else if (ce_in && state == ST_IDLE && cmd_valid_in) begin
      if (cmd_opcode_in == OP_BLOCK_ERASE ||
          cmd_opcode_in == OP_ERASE_ALL) begin
        last_page_valid <= 1'b0;
      end else if (cmd_opcode_in == OP_PAGE_PROG && !(last_page_valid &&
                   last_page == cmd_addr_in)) begin
        last_page <= cmd_addr_in;
        last_page_valid <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // submodules
  // ------------------------------------------------------------
  ssf_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .in_valid_in(wr_valid_in),
    .in_data_in(wr_data_in),
    .in_ready_out(wr_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  ssf_shifter u_shifter (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .start_in(sh_start),
    .tx_byte_in(sh_tx),
    .done_out(sh_done),
    .rx_byte_out(sh_rx),
    .rx_bit_in(rx_sync),
    .link_clk_out(transfer_clock_pin_out),
    .ser_out(serial_input_pin_out)
  );
endmodule

// File: inc/ssf_pkg.sv
// constants shared by the serial flash programmer controller
package ssf_pkg;
  // ------------------------------------------------------------
  // clocking and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam logic [3:0] HALF_CYC =
    4'(LINK_PERIOD_NS / (2 * CLK_PERIOD_NS));
  localparam int DEV_RESET_NS = 1000;
  localparam logic [7:0] RESET_CYC =
    8'((DEV_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // device needs a few of our cycles before busy shows a new transfer
  localparam logic [3:0] GUARD_CYC = 4'h8;
  // ------------------------------------------------------------
  // framing
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int IDX_W = 9;
  localparam logic [8:0] LEN_PAGE = 9'h103;
  localparam logic [8:0] LEN_ADDR_CONF = 9'h004;
  localparam logic [8:0] LEN_CONF = 9'h002;
  localparam logic [8:0] LEN_STATUS = 9'h003;
  localparam logic [8:0] LEN_SINGLE = 9'h001;
  localparam logic [8:0] LEN_VERSION = 9'h009;
  localparam logic [8:0] LEN_ID = 9'h00c;
  localparam logic [8:0] IDX_DATA = 9'h003;
  localparam logic [8:0] IDX_ID = 9'h005;
  localparam logic [7:0] ID_LEN = 8'h07;
  localparam logic [23:0] ID_ADDR = 24'h0f_ffdf;
  localparam logic [7:0] TX_FILL = 8'hff;
  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_PAGE_READ = 8'hff;
  localparam logic [7:0] OP_PAGE_PROG = 8'h41;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h20;
  localparam logic [7:0] OP_ERASE_ALL = 8'ha7;
  localparam logic [7:0] OP_READ_STATUS = 8'h70;
  localparam logic [7:0] OP_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] OP_LOCK_STATUS = 8'h71;
  localparam logic [7:0] OP_LOCK_PROG = 8'h77;
  localparam logic [7:0] OP_LOCK_ENABLE = 8'h7a;
  localparam logic [7:0] OP_LOCK_DISABLE = 8'h75;
  localparam logic [7:0] OP_ID_CHECK = 8'hf5;
  localparam logic [7:0] OP_VERSION = 8'hfb;
  localparam logic [7:0] OP_BOOT_READ = 8'hfc;
  localparam logic [7:0] OP_CHECK_DATA = 8'hfd;
  localparam logic [7:0] CONFIRM = 8'hd0;
  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RESET = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_GUARD = 5'b00100,
    ST_WAIT = 5'b01000,
    ST_SHIFT = 5'b10000
  } ssf_state_t;
endpackage

// File: verilog/ssf_fifo.sv
// write data buffer between the user port and the serial link
`timescale 1ns/1ps
module ssf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push && ce_in) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready_out <= next_count != (AW + 1)'(DEPTH);
      out_valid_out <= next_count != '0;
    end
  end
endmodule

// File: verilog/ssf_shifter.sv
// one full-duplex byte on the link, clock made here, lsb first
`timescale 1ns/1ps
module ssf_shifter
  import ssf_pkg::*;
(
  // clock and control
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // byte request
  input wire logic start_in,
  input wire logic [7:0] tx_byte_in,
  output logic done_out,
  output logic [7:0] rx_byte_out,
  // link, rx already synchronised
  input wire logic rx_bit_in,
  output logic link_clk_out,
  output logic ser_out
);
  logic running;
  logic low_phase;
  logic [3:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] tx_sr;

  // ------------------------------------------------------------
  // bit timing
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      running <= 1'b0;
      low_phase <= 1'b0;
      cnt <= '0;
      bit_idx <= '0;
      tx_sr <= '0;
      rx_byte_out <= '0;
      link_clk_out <= 1'b1;
      ser_out <= 1'b1;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (!running) begin
        if (start_in) begin
          // data changes while clock is low, stable at the rise
          running <= 1'b1;
          tx_sr <= tx_byte_in;
          ser_out <= tx_byte_in[0];
          link_clk_out <= 1'b0;
          low_phase <= 1'b1;
          cnt <= '0;
          bit_idx <= '0;
        end
      end else if (cnt == HALF_CYC - 4'h1) begin
        cnt <= '0;
        if (low_phase) begin
          // device shifted on the fall, so the bit is settled here
          link_clk_out <= 1'b1;
          rx_byte_out <= {rx_bit_in, rx_byte_out[7:1]};
          low_phase <= 1'b0;
        end else if (bit_idx == 3'h7) begin
          running <= 1'b0;
          done_out <= 1'b1;
          ser_out <= 1'b1;
        end else begin
          link_clk_out <= 1'b0;
          bit_idx <= bit_idx + 3'h1;
          ser_out <= tx_sr[bit_idx + 3'h1];
          low_phase <= 1'b1;
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// File: verification/ssf_host_chk.sv
// assertion checker on the controller's ports
`timescale 1ns/1ps
module ssf_host_chk (
  // watched ports
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic refused_out,
  input wire logic done_out,
  input wire logic rd_valid_out,
  input wire logic wr_ready_out,
  input wire logic dev_reset_n_out,
  input wire logic transfer_clock_pin_out,
  input wire logic serial_input_pin_out,
  input wire logic busy_output_pin_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  chk_reset_pins: assert property (disable iff (1'b0) srst_in |=>
    !dev_reset_n_out && transfer_clock_pin_out && !wr_ready_out)
    else $error("pins wrong during reset");
  chk_mode_select: assert property ($rose(dev_reset_n_out)
    |-> transfer_clock_pin_out) else $error("clock low at release");
  chk_reset_hold: assert property ($fell(srst_in)
    |-> !dev_reset_n_out [*8]) else $error("device reset too short");
  chk_clock_half: assert property ($fell(transfer_clock_pin_out) |=>
    !transfer_clock_pin_out [*3] ##1 transfer_clock_pin_out)
    else $error("link clock half wrong");
  chk_data_hold: assert property (!transfer_clock_pin_out &&
    !$fell(transfer_clock_pin_out) |-> $stable(serial_input_pin_out))
    else $error("data moved while clock low");
  chk_busy_wait: assert property (busy_output_pin_in [*3]
    |-> transfer_clock_pin_out) else $error("byte started while busy");
  chk_take_answer: assert property (cmd_ready_out && cmd_valid_in &&
    ce_in |=> refused_out == cmd_ready_out)
    else $error("command answer wrong");
  chk_done_pulse: assert property (done_out
    |-> cmd_ready_out ##1 !done_out) else $error("done not a pulse");
  chk_rd_after: assert property (rd_valid_out |->
    $past(transfer_clock_pin_out) && $past(transfer_clock_pin_out, 4))
    else $error("read byte not after last rise");
  cov_done: cover property (done_out);
  cov_refused: cover property (refused_out);
  cov_read: cover property (rd_valid_out);
  cov_full: cover property ($fell(wr_ready_out));
endmodule

// File: verification/ssf_dev_model.sv
// behavioural flash command port at the far end of the link
`timescale 1ns/1ps
module ssf_dev_model #(
  parameter int BUSY_NS = 100,
  parameter int ERASE_NS = 5000
) (
  // device pins
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic rx_in,
  output logic tx_out,
  output logic busy_out,
  // observation
  output logic [7:0] sum_out,
  output int err_out
);
  logic [7:0] sh, op, mid, high, txb;
  // only address-bearing commands carry middle and high bytes
  logic adr;
  int bitn, idx, len, dly;
  // flash kept blank and unlocked, so every command is taken
  function automatic int cmd_len(input logic [7:0] c);
    case (c)
      8'hff, 8'hfc, 8'h41: return 259;
      8'h20, 8'h77, 8'h71: return 4;
      8'ha7: return 2;
      8'h70, 8'hfd: return 3;
      8'h50, 8'h7a, 8'h75: return 1;
      8'hfb: return 9;
      8'hf5: return 12;
      default: return 0;
    endcase
  endfunction
  initial begin
    {tx_out, busy_out, sum_out, err_out, bitn, idx, txb} = '0;
  end
  // pulled down and busy while held in reset
  always @(negedge reset_n_in) begin
    {tx_out, bitn, idx} = '0;
    busy_out = 1'b1;
  end
  always @(posedge reset_n_in) begin
    if (!link_clk_in) err_out++;
    busy_out <= #(BUSY_NS) 1'b0;
  end
  always @(negedge link_clk_in) if (reset_n_in) begin
    if (bitn == 0 && busy_out) err_out++;
    tx_out = txb[bitn];
  end
  always @(posedge link_clk_in) if (reset_n_in) begin
    sh = {rx_in, sh[7:1]};
    bitn++;
    if (bitn == 8) begin
      bitn = 0;
      // released line shows the inverse, never a stale value
      tx_out = ~tx_out;
      busy_out = 1'b1;
      if (idx == 0) begin
        op = sh;
        {mid, high} = '0;
        len = cmd_len(sh);
        adr = sh inside {8'hff, 8'hfc, 8'h41, 8'h20, 8'h77, 8'h71};
      end
      if (adr && idx == 1) mid = sh;
      if (adr && idx == 2) high = sh;
      if (op == 8'h41 && idx >= 3) sum_out ^= sh;
      if (len != 0) idx++;
      if (idx == len) idx = 0;
      txb = op ^ mid ^ high ^ 8'(idx + 1);
      dly = (idx == 0 && (op == 8'h20 || op == 8'ha7)) ? ERASE_NS : BUSY_NS;
      busy_out <= #(dly) 1'b0;
    end
  end
endmodule

// File: verification/test_ssf_host.sv
// self-checking bench for the serial programmer controller
`timescale 1ns/1ps
`define CHK(n, e, g) compare(n, 32'(e), 32'(g))
module test_ssf_host;
  import ssf_pkg::*;
  logic clk_in, srst_in, cmd_valid_in, wr_valid_in, cmd_ready_out;
  logic wr_ready_out, rd_valid_out, done_out, refused_out, mode_ready_out;
  logic dev_reset_n, link_clk, ser_in, ser_out, busy, feeding;
  logic took = 1'b0;
  logic [7:0] cmd_opcode_in, wr_data_in, rd_data_out, seed, wsum, dev_sum;
  logic [15:0] cmd_addr_in, page;
  logic [55:0] cmd_id_in;
  logic [7:0] ops[10] = '{8'h70, 8'hfb, 8'h71, 8'hfd, 8'h50, 8'h7a,
    8'h75, 8'h77, 8'hf5, 8'ha7};
  int n_errors, check_count, cyc, wleft, nacc, dev_err;
  ssf_host dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .cmd_valid_in(cmd_valid_in), .cmd_opcode_in(cmd_opcode_in),
    .cmd_addr_in(cmd_addr_in), .cmd_id_in(cmd_id_in),
    .cmd_ready_out(cmd_ready_out), .wr_valid_in(wr_valid_in),
    .wr_data_in(wr_data_in), .wr_ready_out(wr_ready_out),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
    .done_out(done_out), .refused_out(refused_out),
    .mode_ready_out(mode_ready_out), .dev_reset_n_out(dev_reset_n),
    .transfer_clock_pin_out(link_clk), .serial_input_pin_out(ser_in),
    .serial_output_pin_in(ser_out), .busy_output_pin_in(busy));
  ssf_dev_model #(.BUSY_NS(100), .ERASE_NS(5000)) dev (
    .reset_n_in(dev_reset_n), .link_clk_in(link_clk), .rx_in(ser_in),
    .tx_out(ser_out), .busy_out(busy), .sum_out(dev_sum),
    .err_out(dev_err));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic compare(input string n, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int rd_first(input logic [7:0] c);
    return (c == 8'hff || c == 8'hfc || c == 8'h71) ? 4 : 2;
  endfunction
  function automatic int rd_count(input logic [7:0] c);
    case (c)
      8'hff, 8'hfc: return 256;
      8'h71: return 1;
      8'h70, 8'hfd: return 2;
      8'hfb: return 8;
      default: return 0;
    endcase
  endfunction
  function automatic logic [7:0] addr_mix(input logic [7:0] c);
    if (c inside {8'hff, 8'hfc, 8'h71, 8'h41, 8'h20, 8'h77})
      return cmd_addr_in[7:0] ^ cmd_addr_in[15:8];
    return 8'h00;
  endfunction
  task automatic run_cmd(input logic [7:0] op, input logic refuse);
    int n;
    int nrd;
    logic [7:0] e;
    n = 0;
    nrd = 0;
    for (int i = 0; i < 400 && !cmd_ready_out; i++) @(negedge clk_in);
    cmd_opcode_in = op;
    cmd_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    `CHK("refused", refuse, refused_out);
    `CHK("ready", refuse, cmd_ready_out);
    while (!refuse && done_out !== 1'b1 && n < 30000) begin
      if (rd_valid_out) begin
        e = op ^ addr_mix(op) ^ 8'(rd_first(op) + nrd);
        `CHK("rd_data", e, rd_data_out);
        nrd++;
      end
      n++;
      @(negedge clk_in);
    end
    `CHK("rd_count", rd_count(op), nrd);
    `CHK("done", !refuse, done_out);
    // let an edge pass so valid is not lowered and raised in one step
    if (refuse) @(negedge clk_in);
  endtask
  // fills the buffer ahead of the command, then trickles with the link
  task automatic program_page();
    cmd_addr_in = page;
    wleft = 256;
    nacc = 0;
    feeding = 1'b1;
    repeat (40) @(negedge clk_in);
    `CHK("fifo_fill", FIFO_DEPTH, nacc);
    `CHK("wr_ready", 0, wr_ready_out);
    run_cmd(8'h41, 1'b0);
    `CHK("prog_count", 256, nacc);
    `CHK("prog_sum", wsum, dev_sum);
  endtask
  // ------------------------------------------------------------
  // clock, timeout, write feeder
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      complete_run();
    end
  end
  always @(posedge clk_in) took <= wr_valid_in && wr_ready_out;
  always @(negedge clk_in) if (feeding) begin
    if (took) begin
      wsum ^= wr_data_in;
      wleft--;
      nacc++;
      wr_data_in = lfsr(wr_data_in);
    end
    wr_valid_in = wleft != 0;
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {srst_in, seed, wr_data_in} = {1'b1, 8'h33, 8'h33};
    {cmd_valid_in, wr_valid_in, feeding, cmd_opcode_in} = '0;
    {cmd_addr_in, wsum, n_errors, check_count, cyc, wleft, nacc} = '0;
    cmd_id_in = 56'h01_2345_6789_abcd;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 200 && !mode_ready_out; i++) @(negedge clk_in);
    `CHK("mode_ready", 1, mode_ready_out);
    foreach (ops[i]) begin
      seed = lfsr(seed);
      cmd_addr_in = {seed, lfsr(seed)};
      run_cmd(ops[i], 1'b0);
    end
    foreach (ops[i]) run_cmd(ops[i] ^ 8'h0c, 1'b1);
    run_cmd(8'hff, 1'b0);
    page = {lfsr(seed), seed};
    program_page();
    run_cmd(8'h41, 1'b1);
    cmd_addr_in = {page[15:8], 8'hff};
    run_cmd(8'h20, 1'b0);
    program_page();
    `CHK("dev_errors", 0, dev_err);
    complete_run();
  end
endmodule
bind ssf_host ssf_host_chk chk (.clk_in(clk_in), .srst_in(srst_in),
  .ce_in(ce_in), .cmd_valid_in(cmd_valid_in),
  .cmd_ready_out(cmd_ready_out), .refused_out(refused_out),
  .done_out(done_out), .rd_valid_out(rd_valid_out),
  .wr_ready_out(wr_ready_out), .dev_reset_n_out(dev_reset_n_out),
  .transfer_clock_pin_out(transfer_clock_pin_out),
  .serial_input_pin_out(serial_input_pin_out),
  .busy_output_pin_in(busy_output_pin_in));
